// >>> src/octal_dac_consts.vh
// constants for the octal converter command decoder
// assumes inclusion by the decoder and its byte receiver only
`ifndef OCTAL_DAC_CONSTS_VH
`define OCTAL_DAC_CONSTS_VH
`define CMD_GLOBAL_LOAD 4'h2
`define CMD_POWER 4'h4
`define ACC_BROADCAST 4'hF
`define PMODE_HI_BIT 14
`define PMODE_LO_BIT 13
`define PSEL_TOP_BIT 12
`define PSEL_BOT_BIT 5
`define PMODE_ON 2'h0
`define PMODE_1K 2'h1
`define PMODE_100K 2'h2
`define PMODE_HIZ 2'h3
`define DEV_ADDR_DEFAULT 7'h48
`define FRAME_BYTES 2'h3
`endif

// >>> src/frame_bytes_rx.v
// two-wire slave receiver: address match, byte shifting, acknowledge
// assumes scl/sda already synchronised into the i_mclk domain
`timescale 1ns/100ps
`include "octal_dac_consts.vh"
module frame_bytes_rx #(
   parameter [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT
) (
   input wire i_mclk,
   input wire i_rst,
   input wire i_scl_rise,
   input wire i_scl_fall,
   input wire i_sda,
   input wire i_start,
   input wire i_stop,
   output reg o_sda_oe,
   output reg o_byte_valid,
   output reg [7:0] o_byte,
   output reg o_frame_open
);
   localparam ST_IDLE = 2'd0;
   localparam ST_ADDR = 2'd1;
   localparam ST_DATA = 2'd2;
   reg [1:0] state_reg;
   reg [7:0] shift_reg;
   reg [3:0] bit_cnt_reg;
   // shift on rising scl, drive acknowledge on falling scl
   always @(posedge i_mclk) begin
      o_byte_valid <= 1'b0;
      if (i_rst || i_stop) begin
         state_reg <= ST_IDLE;
         bit_cnt_reg <= 4'h0;
         o_sda_oe <= 1'b0;
         o_frame_open <= 1'b0;
         shift_reg <= 8'h00;
         o_byte <= 8'h00;
      end else if (i_start) begin
         state_reg <= ST_ADDR;
         bit_cnt_reg <= 4'h0;
         o_sda_oe <= 1'b0;
         o_frame_open <= 1'b0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               o_sda_oe <= 1'b0;
            end
            ST_ADDR, ST_DATA: begin
               if (i_scl_rise && bit_cnt_reg < 4'h8) begin
                  shift_reg <= {shift_reg[6:0], i_sda};
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end else if (i_scl_rise && bit_cnt_reg == 4'h8) begin
                  bit_cnt_reg <= 4'h9;
               end
               if (i_scl_fall && bit_cnt_reg == 4'h8) begin
                  if (state_reg == ST_ADDR) begin
                     // write to our address only
                     if (shift_reg[7:1] == DEV_ADDR && !shift_reg[0]) begin
                        o_sda_oe <= 1'b1;
                        o_frame_open <= 1'b1;
                     end else begin
                        state_reg <= ST_IDLE;
                     end
                  end else begin
                     o_sda_oe <= 1'b1;
                     o_byte <= shift_reg;
                     o_byte_valid <= 1'b1;
                  end
               end else if (i_scl_fall && bit_cnt_reg == 4'h9) begin
                  o_sda_oe <= 1'b0;
                  bit_cnt_reg <= 4'h0;
                  if (state_reg == ST_ADDR) begin
                     state_reg <= ST_DATA;
                  end
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end
endmodule

// >>> src/octal_dac_ctrl.v
// octal 12-bit converter command decoder: global load and power control
// assumes scl/sda pins from an external two-wire controller, async to i_mclk
// Operation
// - frame is command byte, then two data bytes
// - command 0010 channel A-H: load, update all
// - code bits 11:4 then 3:0, low nibble ignored
// - access 1xxx except 1111 changes nothing
// - access 1111 writes all inputs, updates all
// - power mode 00 powers on selected channels
// - modes 01/10/11 power down with chosen termination
`timescale 1ns/100ps
`include "octal_dac_consts.vh"
module octal_dac_ctrl #(
   parameter [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT
) (
   input wire i_mclk,
   input wire i_rst,
   input wire i_scl,
   input wire i_sda,
   output reg o_sda_out,
   output reg o_sda_oe,
   output reg [95:0] o_input_codes,
   output reg [95:0] o_output_codes,
   output reg o_load_outputs_strobe,
   output reg [7:0] o_powered_down,
   output reg [15:0] o_pd_termination
);
   reg [1:0] scl_meta_reg;
   reg [1:0] sda_meta_reg;
   reg scl_prev_reg;
   reg sda_prev_reg;
   wire scl_s;
   wire sda_s;
   wire scl_rise;
   wire scl_fall;
   wire start_cond;
   wire stop_cond;
   wire rx_oe;
   wire rx_valid;
   wire [7:0] rx_byte;
   wire rx_open;
   reg [1:0] byte_cnt_reg;
   reg [7:0] cmd_reg;
   reg [7:0] msb_reg;
   reg [95:0] in_next;
   reg [7:0] pd_next;
   reg [15:0] term_next;
   reg [3:0] cmd_n;
   reg [3:0] acc_n;
   reg [7:0] sel;
   reg [1:0] mode;
   reg [11:0] code;
   reg do_update;
   wire is_load_cmd;
   wire is_power_cmd;
   wire acc_single;
   wire acc_bcast;
   wire commit;
   integer k;
   // byte positions within a frame, after the address byte
   localparam BYTE_CMD = 2'h0;
   localparam BYTE_MSB = 2'h1;
   localparam BYTE_LSB = 2'h2;
   // two-flop synchronisers on both pins
   always @(posedge i_mclk) begin
      if (i_rst) begin
         scl_meta_reg <= 2'b11;
         sda_meta_reg <= 2'b11;
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end else begin
         scl_meta_reg <= {scl_meta_reg[0], i_scl};
         sda_meta_reg <= {sda_meta_reg[0], i_sda};
         scl_prev_reg <= scl_meta_reg[1];
         sda_prev_reg <= sda_meta_reg[1];
      end
   end
   assign scl_s = scl_meta_reg[1];
   assign sda_s = sda_meta_reg[1];
   assign scl_rise = scl_s && !scl_prev_reg;
   assign scl_fall = !scl_s && scl_prev_reg;
   assign start_cond = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
   assign stop_cond = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;
   // byte receiver
   frame_bytes_rx #(.DEV_ADDR(DEV_ADDR)) u_rx (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_scl_rise(scl_rise),
      .i_scl_fall(scl_fall),
      .i_sda(sda_s),
      .i_start(start_cond),
      .i_stop(stop_cond),
      .o_sda_oe(rx_oe),
      .o_byte_valid(rx_valid),
      .o_byte(rx_byte),
      .o_frame_open(rx_open)
   );
   always @* begin
      cmd_n = cmd_reg[7:4];
      acc_n = cmd_reg[3:0];
   end
   // command classes, only acted on at commit
   assign is_load_cmd = (cmd_n == `CMD_GLOBAL_LOAD);
   assign is_power_cmd = (cmd_n == `CMD_POWER);
   assign acc_single = !acc_n[3];
   assign acc_bcast = (acc_n == `ACC_BROADCAST);
   assign commit = rx_open && rx_valid && (byte_cnt_reg == BYTE_LSB);
   always @* begin
      code = {msb_reg, rx_byte[7:4]};
   end
   // mode and selects, channel H at the top
   always @* begin
      mode = {msb_reg[`PMODE_HI_BIT - 8], msb_reg[`PMODE_LO_BIT - 8]};
      sel = {msb_reg[`PSEL_TOP_BIT - 8:0], rx_byte[7:`PSEL_BOT_BIT]};
   end
   // next input registers for the global load command
   always @* begin
      in_next = o_input_codes;
      do_update = 1'b0;
      if (is_load_cmd) begin
         if (acc_single) begin
            in_next[acc_n[2:0]*12 +: 12] = code;
            do_update = 1'b1;
         end else if (acc_bcast) begin
            in_next = {8{code}};
            do_update = 1'b1;
         end
      end
   end
   // next power state for the power command
   always @* begin
      pd_next = o_powered_down;
      term_next = o_pd_termination;
      if (is_power_cmd) begin
         for (k = 0; k < 8; k = k + 1) begin
            if (sel[k]) begin
               pd_next[k] = (mode != `PMODE_ON);
               term_next[k*2 +: 2] = mode;
            end
         end
      end
   end
   always @(posedge i_mclk) begin
      if (i_rst) begin
         byte_cnt_reg <= BYTE_CMD;
         cmd_reg <= 8'h00;
         msb_reg <= 8'h00;
      end else if (!rx_open) begin
         byte_cnt_reg <= BYTE_CMD;
      end else if (rx_valid) begin
         case (byte_cnt_reg)
            BYTE_CMD: begin
               cmd_reg <= rx_byte;
               byte_cnt_reg <= BYTE_MSB;
            end
            BYTE_MSB: begin
               msb_reg <= rx_byte;
               byte_cnt_reg <= BYTE_LSB;
            end
            BYTE_LSB: begin
               byte_cnt_reg <= BYTE_CMD; // extra bytes open a new frame
            end
            default: begin
               byte_cnt_reg <= BYTE_CMD;
            end
         endcase
      end
   end
   always @(posedge i_mclk) begin
      if (i_rst) begin
         o_input_codes <= {96{1'b0}};
         o_output_codes <= {96{1'b0}};
      end else if (commit) begin
         o_input_codes <= in_next;
         if (do_update) begin
            o_output_codes <= in_next;
         end
      end
   end
   // one-cycle pulse as the output registers reload
   always @(posedge i_mclk) begin
      if (i_rst) begin
         o_load_outputs_strobe <= 1'b0;
      end else begin
         o_load_outputs_strobe <= commit && do_update;
      end
   end
   always @(posedge i_mclk) begin
      if (i_rst) begin
         o_powered_down <= 8'h00;
         o_pd_termination <= 16'h0000;
      end else if (commit) begin
         o_powered_down <= pd_next;
         o_pd_termination <= term_next;
      end
   end
   // open-drain data pin: only ever pulls low, for the acknowledge
   always @(posedge i_mclk) begin
      if (i_rst) begin
         o_sda_out <= 1'b0;
         o_sda_oe <= 1'b0;
      end else begin
         o_sda_out <= 1'b0;
         o_sda_oe <= rx_oe;
      end
   end
endmodule

// >>> tb/bus_host.sv
// bus controller model: start, byte with acknowledge slot, stop
// assumes the bench resolves the pulled-up data line
`timescale 1ns/100ps
module bus_host (
   output logic o_scl = 1'b1,
   output logic o_sda_low = 1'b0,
   input wire i_sda_line
);
   task automatic wr(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         #40 o_sda_low = ~b[i];
         #40 o_scl = 1'b1;
         #80 o_scl = 1'b0;
      end
      #40 o_sda_low = 1'b0;
      #40 o_scl = 1'b1;
      #70 ack = ~i_sda_line;
      #10 o_scl = 1'b0;
   endtask
   // start with the clock high
   task automatic start;
      o_sda_low = 1'b1;
      #80 o_scl = 1'b0;
   endtask
   task automatic stop;
      #40 o_sda_low = 1'b1;
      #40 o_scl = 1'b1;
      #40 o_sda_low = 1'b0;
      #80;
   endtask
endmodule

// >>> tb/dac_ctrl_checker.sv
// checker: load, update and power relations at the decoder ports
// assumes binding onto octal_dac_ctrl
`timescale 1ns/100ps
module dac_ctrl_checker (
   input wire i_mclk,
   input wire i_rst,
   input wire i_scl,
   input wire o_sda_out,
   input wire o_sda_oe,
   input wire [95:0] o_input_codes,
   input wire [95:0] o_output_codes,
   input wire o_load_outputs_strobe,
   input wire [7:0] o_powered_down,
   input wire [15:0] o_pd_termination
);
   wire [7:0] pd_calc;
   // power-down implied by each termination field
   genvar g;
   for (g = 0; g < 8; g = g + 1) begin : g_pd
      assign pd_calc[g] = |o_pd_termination[2*g+:2];
   end
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   AST_SDA_OPEN: assert property (o_sda_out == 1'b0)
      else $error("sda driven high");
   AST_ACK_SCL_LOW: assert property ($changed(o_sda_oe) |-> !$past(i_scl))
      else $error("sda moved while scl high");
   AST_IN_STROBE: assert property (!$stable(o_input_codes) |-> ##[0:2] o_load_outputs_strobe)
      else $error("input write without update");
   AST_STROBE_ONE: assert property (o_load_outputs_strobe |=> !o_load_outputs_strobe)
      else $error("strobe too long");
   AST_OUT_CAUSE: assert property (!$stable(o_output_codes) |->
      o_load_outputs_strobe || $past(o_load_outputs_strobe))
      else $error("outputs moved without strobe");
   AST_OUT_COPY: assert property (o_load_outputs_strobe |=> o_output_codes == o_input_codes)
      else $error("outputs differ from inputs");
   AST_PWR_SPLIT: assert property (!$stable(o_pd_termination) |-> $stable(o_input_codes))
      else $error("power and load together");
   AST_PD_TERM: assert property (o_powered_down == pd_calc)
      else $error("power state and mode disagree");
   AST_IDLE_HOLD: assert property (i_scl [*8] |->
      $stable({o_input_codes, o_pd_termination}))
      else $error("change while bus idle");
endmodule
bind octal_dac_ctrl dac_ctrl_checker u_chk (.i_mclk(i_mclk), .i_rst(i_rst), .i_scl(i_scl),
   .o_sda_out(o_sda_out), .o_input_codes(o_input_codes), .o_output_codes(o_output_codes),
   .o_load_outputs_strobe(o_load_outputs_strobe), .o_powered_down(o_powered_down),
   .o_pd_termination(o_pd_termination), .o_sda_oe(o_sda_oe));

// >>> tb/tb_top.sv
// bench: bus model frames, decoder outputs against a behavioural model
// assumes the decoder's default device address 7'h48
`timescale 1ns/100ps
module tb_top;
   logic i_mclk = 1'b0;
   logic i_rst = 1'b1;
   logic ack;
   logic [7:0] r;
   logic [11:0] ein[8] = '{default: 0};
   logic [11:0] eout[8] = '{default: 0};
   logic [1:0] eterm[8] = '{default: 0};
   wire scl, lo, sda, so, oe, stb;
   wire [95:0] inc, outc;
   wire [7:0] pd;
   wire [15:0] term;
   int err_total = 0, checked = 0, cyc = 0, nstb = 0, xstb = 0, seed = 83141;
   assign sda = ~(lo | (oe & ~so));
   always #10 i_mclk = ~i_mclk;
   bus_host u_host (.o_scl(scl), .o_sda_low(lo), .i_sda_line(sda));
   octal_dac_ctrl u_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda),
      .o_sda_out(so), .o_sda_oe(oe), .o_input_codes(inc), .o_output_codes(outc),
      .o_load_outputs_strobe(stb), .o_powered_down(pd), .o_pd_termination(term));
   // strobe count and hang limit
   always @(posedge i_mclk) begin
      cyc++;
      if (stb === 1'b1)
         nstb++;
      if (cyc == 20000) begin
         err_total++;
         end_sim;
      end
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // send n bytes after the address, then update the model and compare
   task automatic frame(input logic [7:0] a, c, m, l, input int n);
      logic [7:0] b[4];
      logic [7:0] s;
      b = '{a, c, m, l};
      s = {m[4:0], l[7:5]};
      u_host.start();
      for (int i = 0; i <= n; i++) begin
         u_host.wr(b[i], ack);
         chk(ack, a == 8'h90);
      end
      u_host.stop();
      repeat (8) @(negedge i_mclk);
      if (a == 8'h90 && n == 3 && c[7:4] == 4'h2 && (!c[3] || c[3:0] == 4'hf)) begin
         for (int k = 0; k < 8; k++)
            if (c[3:0] == 4'hf || k == c[2:0])
               ein[k] = {m, l[7:4]};
         eout = ein;
         xstb++;
      end
      for (int k = 0; k < 8; k++)
         if (a == 8'h90 && n == 3 && c[7:4] == 4'h4 && s[k])
            eterm[k] = m[6:5];
      for (int k = 0; k < 8; k++) begin
         chk(inc[12*k+:12], ein[k]);
         chk(outc[12*k+:12], eout[k]);
         chk(term[2*k+:2], eterm[k]);
         chk(pd[k], eterm[k] != 2'h0);
      end
      chk(nstb, xstb);
   endtask
   // reset, then each group of frames
   initial begin
      repeat (20) @(negedge i_mclk);
      i_rst = 1'b0;
      repeat (4) @(negedge i_mclk);
      for (int k = 0; k < 15; k++)
         frame(8'h90, 8'h20 + k, $random(seed), $random(seed), 3);
      $display("test channel and invalid access done");
      frame(8'h90, 8'h2f, $random(seed), $random(seed), 3);
      frame(8'h90, 8'h2f, $random(seed), $random(seed), 2);
      frame(8'h90, 8'h31, $random(seed), $random(seed), 3);
      frame(8'h92, 8'h21, $random(seed), $random(seed), 3);
      $display("test broadcast and short frames done");
      for (int k = 1; k < 5; k++) begin
         r = $random(seed);
         frame(8'h90, 8'h40, {1'b0, k[1:0], r[4:0]}, $random(seed), 3);
      end
      $display("test power modes done");
      end_sim;
   end
endmodule
